// [inc/servo_pkg.sv]
/*
 * shared constants of the servo target/error accumulator.
 * assumes one 50 MHz clock and a 24-bit operand bus from pins.
 */
package servo_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int POS_W = 24;
	localparam int SLICE_W = 8;
	localparam int SLICES = 3;
	localparam int GROUPS_PER_SLICE = 3;
	localparam int GROUP_W = 3;
	localparam int STEPS = SLICES * GROUPS_PER_SLICE;
	localparam int STEP_W = 4;
	localparam int DAC_W = 8;
	localparam int MAG_W = 7;
	localparam int SYNC_W = 2;
	localparam logic [POS_W-1:0] TARGET_RST = 24'h000000;
	localparam logic [POS_W-1:0] ACC_RST = 24'h000000;
	localparam logic [DAC_W-1:0] DAC_RST = 8'h00;
	localparam logic [MAG_W-1:0] MAG_ZERO = 7'h00;
	localparam logic [MAG_W-1:0] MAG_FULL = 7'h7f;
	localparam logic [SLICE_W-1:0] RAIL_LOW = 8'h00;
	localparam logic [SLICE_W-1:0] RAIL_HIGH = 8'hff;
	localparam logic [STEP_W-1:0] STEP_LAST = 4'h8;

	typedef enum logic {MODE_UPDATE, MODE_CONTROL} mode_t;
	typedef enum logic {ST_IDLE, ST_RUN} state_t;
endpackage

// [hw/servo_target_error_accumulator.sv]
/*
 * 24-bit servo accumulator: adds host steps into a stored target, or
 * adds the inverted position count plus one to it, subtracting the count, to form the error.
 * assumes: bus, capture/load clocks, mode and clear come from pins and
 * are resynchronised here; the slow strobes last several clk periods.
 */
// Function
// - target register holds zero after start-up.
// - step on the bus is captured on the input capture clock.
// - update mode adds captured step to target into the accumulator.
// - target load clock copies the accumulator into the target, in update mode only.
// - after alignment, counter and accumulator values are cleared.
// - control mode captures the inverted position count from the bus.
// - control mode forces the lowest carry in to one.
// - control mode registers target minus position as the error.
// - upper two slices each give rail-high and rail-low flags.
// - dac word: top bit direction, magnitude from flags and sign bit.
// - flags near zero force magnitude 0, mostly ones force all 1.
// - each adder bit sum is xor of operands and carry.
// - each adder bit carry is majority of operands and carry.
// - carry groups of 3,3,2 bits, group carry registered to next cycle.
// - control mode updates error and dac word once per capture clock.
// - 24 bits as three 8-bit slices, carry out chained onward.
// - full result valid nine cycles after operand capture.
// - accumulator output stays driven while the target loads.
module servo_target_error_accumulator
	import servo_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// shared operand bus and its strobes
	input wire logic [servo_pkg::POS_W-1:0] operand_bus,
	input wire logic input_capture_clock,
	input wire logic target_load_clock,
	// mode and alignment clear
	input wire logic control_mode,
	input wire logic align_clear,
	// accumulator and status
	output logic [servo_pkg::POS_W-1:0] accumulator,
	output logic [servo_pkg::POS_W-1:0] target,
	output logic carry_output,
	output logic busy,
	output logic result_valid,
	// dac stage
	output logic [servo_pkg::DAC_W-1:0] dac_word,
	output logic [3:0] offscale
);
	import servo_pkg::*;

	// refused at elaboration: stepping assumes three groups per slice
	if (POS_W != SLICES * SLICE_W || STEPS - 1 != int'(STEP_LAST))
	begin
		$error("accumulator geometry does not match");
	end

	typedef struct packed {
		logic [SYNC_W-1:0] cap_sync;
		logic cap_prev;
		logic [SYNC_W-1:0] load_sync;
		logic load_prev;
		logic [SYNC_W-1:0] mode_sync;
		logic [SYNC_W-1:0] clr_sync;
		logic clr_prev;
		logic [POS_W-1:0] bus_s1;
		logic [POS_W-1:0] bus_s2;
		logic [POS_W-1:0] operand;
		logic [POS_W-1:0] target;
		logic [POS_W-1:0] acc;
		state_t state;
		mode_t op_mode;
		logic [STEP_W-1:0] step;
		logic carry;
		logic slice_carry;
		logic valid;
		logic [STEP_W-1:0] run_len;
		logic [DAC_W-1:0] dac;
	} regs_t;

	regs_t r;
	regs_t next_r;

	// full adder bit
	function automatic logic fa_sum(logic a, logic b, logic c);
		return a ^ b ^ c;
	endfunction

	function automatic logic fa_carry(logic a, logic b, logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// first bit of a step: groups of 3,3,2 within each 8-bit slice
	function automatic int group_lo(logic [STEP_W-1:0] s);
		return (int'(s) / GROUPS_PER_SLICE) * SLICE_W
			+ (int'(s) % GROUPS_PER_SLICE) * GROUP_W;
	endfunction

	function automatic int group_hi(logic [STEP_W-1:0] s);
		int h;
		h = group_lo(s) + GROUP_W - 1;
		if ((int'(s) % GROUPS_PER_SLICE) == GROUPS_PER_SLICE - 1)
			h = (int'(s) / GROUPS_PER_SLICE) * SLICE_W + SLICE_W - 1;
		return h;
	endfunction

	// rail flags and dac word from an accumulator value
	function automatic logic [3:0] rails(logic [POS_W-1:0] v);
		return {v[23:16] == RAIL_HIGH, v[23:16] == RAIL_LOW,
			v[15:8] == RAIL_HIGH, v[15:8] == RAIL_LOW};
	endfunction

	function automatic logic [DAC_W-1:0] dac_of(logic [POS_W-1:0] v);
		logic [3:0] f;
		logic [MAG_W-1:0] m;
		f = rails(v);
		if (f[2] && f[0])
			m = MAG_ZERO;
		else if (f[3] && f[1])
			m = MAG_FULL;
		else if (v[POS_W-1])
			m = MAG_ZERO; // large error: saturate toward its sign
		else
			m = MAG_FULL;
		// top bit high means clockwise (positive error)
		return {~v[POS_W-1], m};
	endfunction

	logic cap_edge;
	logic load_edge;
	logic clr_edge;
	logic mode_is_ctrl;
	logic step_cin;
	logic [POS_W-1:0] b_eff;

	// strobe edges are seen only on synchronised copies
	assign cap_edge = r.cap_sync[1] & ~r.cap_prev;
	assign load_edge = r.load_sync[1] & ~r.load_prev;
	assign clr_edge = r.clr_sync[1] & ~r.clr_prev;
	assign mode_is_ctrl = r.mode_sync[1];
	// control mode: bus already carries the inverted count, carry in 1
	assign step_cin = (r.step == '0) ? (r.op_mode == MODE_CONTROL)
		: r.carry;
	assign b_eff = r.operand;

	always_comb
	begin
		int lo;
		int hi;
		logic c;
		lo = group_lo(r.step);
		hi = group_hi(r.step);
		c = step_cin;
		next_r = r;
		next_r.cap_sync = {r.cap_sync[0], input_capture_clock};
		next_r.load_sync = {r.load_sync[0], target_load_clock};
		next_r.mode_sync = {r.mode_sync[0], control_mode};
		next_r.clr_sync = {r.clr_sync[0], align_clear};
		next_r.cap_prev = r.cap_sync[1];
		next_r.load_prev = r.load_sync[1];
		next_r.clr_prev = r.clr_sync[1];
		next_r.bus_s1 = operand_bus;
		next_r.bus_s2 = r.bus_s1;
		next_r.run_len = (r.state == ST_RUN) ? r.run_len + 4'h1 : '0;
		next_r.valid = 1'b0;
		case (r.state)
			ST_IDLE:
			begin
				if (cap_edge)
				begin
					next_r.operand = r.bus_s2;
					next_r.op_mode = mode_is_ctrl ? MODE_CONTROL
						: MODE_UPDATE;
					next_r.step = '0;
					next_r.state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				// one group of 3, 3 or 2 bits per cycle, carry kept for the next
				for (int i = 0; i < POS_W; i++)
				begin
					if (i >= lo && i <= hi)
					begin
						next_r.acc[i] = fa_sum(r.target[i], b_eff[i], c);
						c = fa_carry(r.target[i], b_eff[i], c);
					end
				end
				next_r.carry = c;
				if ((int'(r.step) % GROUPS_PER_SLICE)
					== GROUPS_PER_SLICE - 1)
					next_r.slice_carry = c;
				if (r.step == STEP_LAST)
				begin
					next_r.state = ST_IDLE;
					next_r.valid = 1'b1;
					if (r.op_mode == MODE_CONTROL)
						next_r.dac = dac_of(next_r.acc);
				end
				else
					next_r.step = r.step + 4'h1;
			end
			default:
				next_r.state = ST_IDLE;
		endcase
		// new target only from the accumulator, update mode only
		if (load_edge && !mode_is_ctrl)
			next_r.target = r.acc;
		// alignment done: start from zero, abandon any pending sum
		if (clr_edge)
		begin
			next_r.target = TARGET_RST;
			next_r.acc = ACC_RST;
			next_r.state = ST_IDLE;
			next_r.valid = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.target <= TARGET_RST;
			r.acc <= ACC_RST;
			r.dac <= DAC_RST;
			r.state <= ST_IDLE;
			r.op_mode <= MODE_UPDATE;
		end
		else
			r <= next_r;
	end

	// outputs never float: the accumulator is always presented
	assign accumulator = r.acc;
	assign target = r.target;
	assign carry_output = r.slice_carry;
	assign busy = (r.state == ST_RUN);
	assign result_valid = r.valid;
	assign dac_word = r.dac;
	assign offscale = rails(r.acc);

	// reference sum, only read by the checks below
	logic [POS_W-1:0] exp_sum;
	assign exp_sum = r.target + r.operand
		+ {{(POS_W-1){1'b0}}, r.op_mode == MODE_CONTROL};

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence run_done;
		result_valid && !busy && int'(r.run_len) == STEPS;
	endsequence
	sequence run_going;
		int'(r.run_len) < STEPS;
	endsequence

	nine_cycle_run_a: assert property ($fell(busy)
		&& !$past(clr_edge) |-> run_done)
		else $error("sum not complete after nine cycles");
	run_bound_a: assert property (busy |-> run_going)
		else $error("sum running longer than nine cycles");
	result_sum_a: assert property (result_valid
		&& !$past(clr_edge) && $past(target) == target
		|-> accumulator == $past(exp_sum))
		else $error("accumulator result wrong");
	carry_init_a: assert property (busy && r.step == '0
		&& !clr_edge |=> accumulator[0] == ($past(target[0])
		^ $past(r.operand[0]) ^ ($past(r.op_mode) == MODE_CONTROL)))
		else $error("lowest carry in wrong for mode");
	target_load_a: assert property (load_edge && !mode_is_ctrl
		&& !clr_edge |=> target == $past(accumulator))
		else $error("target not loaded from accumulator");
	target_hold_a: assert property (!(load_edge && !mode_is_ctrl)
		&& !clr_edge |=> $stable(target))
		else $error("target changed without a load");
	align_clear_a: assert property (clr_edge
		|=> target == '0 && accumulator == '0 && !busy)
		else $error("alignment clear incomplete");
	dac_zero_a: assert property ($rose(result_valid)
		&& r.op_mode == MODE_CONTROL && offscale[2] && offscale[0]
		|-> dac_word[MAG_W-1:0] == MAG_ZERO)
		else $error("dac magnitude not forced to zero");
	dac_full_a: assert property ($rose(result_valid)
		&& r.op_mode == MODE_CONTROL && offscale[3] && offscale[1]
		|-> dac_word == {1'b0, MAG_FULL})
		else $error("dac not full scale on rail high");
	reset_zero_a: assert property (disable iff (1'b0)
		$past(srst) && !srst |-> target == '0 && !busy)
		else $error("target not zero after reset");
endmodule

// [testbench/servo_far_side.sv]
/*
 * host step driver and 24-bit position counter sharing the operand bus.
 * assumes one clock and a synchronous active-high reset.
 */
module servo_far_side
	import servo_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// host side
	input wire logic host_en,
	input wire logic [servo_pkg::POS_W-1:0] host_step,
	// counter controls
	input wire logic clear,
	input wire logic preset,
	input wire logic [servo_pkg::POS_W-1:0] preset_val,
	input wire logic pulse,
	input wire logic up,
	// shared bus
	output logic [servo_pkg::POS_W-1:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [POS_W-1:0] count;
	// preset stands in for a long encoder run, saving sim time
	always_ff @(posedge clk)
	begin
		if (srst || clear)
			count <= '0;
		else if (preset)
			count <= preset_val;
		else if (pulse)
			count <= up ? count + 1'b1 : count - 1'b1;
	end
	// only one driver: counter output released while host drives
	assign bus = host_en ? host_step : ~count;
endmodule

// [testbench/tb_top.sv]
/*
 * self-checking bench for the servo accumulator.
 * assumes the far-side model and a 50 MHz clock.
 */
module tb_top;
	import servo_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic icc = 1'b0, tlc = 1'b0, control_mode = 1'b0, align_clear = 1'b0;
	logic host_en = 1'b1, preset = 1'b0, pulse = 1'b0, up = 1'b1;
	logic [POS_W-1:0] host_step = 24'h000000, preset_val = 24'h000000;
	logic [POS_W-1:0] bus, accumulator, target;
	logic carry_output, busy, result_valid;
	logic [DAC_W-1:0] dac_word;
	logic [3:0] offscale;
	int n_mismatch = 0, compares = 0, cycles = 0;
	always #10 clk = ~clk;
	servo_far_side far_u (.clk(clk), .srst(srst), .host_en(host_en),
		.host_step(host_step), .clear(align_clear), .preset(preset),
		.preset_val(preset_val), .pulse(pulse), .up(up), .bus(bus));
	servo_target_error_accumulator dut_u (.clk(clk), .srst(srst),
		.operand_bus(bus), .input_capture_clock(icc),
		.target_load_clock(tlc), .control_mode(control_mode),
		.align_clear(align_clear), .accumulator(accumulator),
		.target(target), .carry_output(carry_output), .busy(busy),
		.result_valid(result_valid), .dac_word(dac_word),
		.offscale(offscale));
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the fewer than two hundred cycles used
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// bus settles before the strobe and stays until the result
	task automatic capture();
		int nb;
		nb = 0;
		tick(2);
		icc = 1'b1;
		for (int i = 0; i < 40 && result_valid !== 1'b1; i++)
		begin
			tick(1);
			if (busy === 1'b1)
				nb++;
		end
		chk("busy_cycles", 24'(nb), 24'h000009);
		chk("valid", 24'(result_valid), 24'h000001);
		icc = 1'b0;
		tick(4);
	endtask
	task automatic load();
		tlc = 1'b1;
		tick(4);
		tlc = 1'b0;
		tick(4);
	endtask
	task automatic t_update(logic [23:0] st, logic [23:0] ea, logic c);
		host_en = 1'b1;
		control_mode = 1'b0;
		host_step = st;
		capture();
		chk("acc_sum", accumulator, ea);
		chk("carry", 24'(carry_output), 24'(c));
		load();
		chk("target_load", target, ea);
	endtask
	task automatic t_control(logic [23:0] p, int n, logic [23:0] ea,
		logic [7:0] ed, logic [3:0] eo);
		host_en = 1'b0;
		control_mode = 1'b1;
		preset_val = p;
		preset = 1'b1;
		tick(1);
		preset = 1'b0;
		pulse = (n > 0);
		tick(n > 0 ? n : 1);
		pulse = 1'b0;
		capture();
		chk("acc_error", accumulator, ea);
		chk("dac", 24'(dac_word), 24'(ed));
		chk("offscale", 24'(offscale), 24'(eo));
	endtask
	// load strobe in control mode must leave the target alone
	task automatic t_refuse();
		load();
		chk("target_kept", target, 24'h010122);
	endtask
	task automatic t_clear();
		align_clear = 1'b1;
		tick(4);
		align_clear = 1'b0;
		tick(4);
		chk("clr_target", target, 24'h000000);
		chk("clr_acc", accumulator, 24'h000000);
	endtask
	initial
	begin
		tick(20);
		srst = 1'b0;
		chk("rst_target", target, 24'h000000);
		chk("rst_offscale", 24'(offscale), 24'h000005);
		tick(4);
		t_update(24'h010123, 24'h010123, 1'b0);
		t_update(24'hffffff, 24'h010122, 1'b1);
		t_control(24'h000122, 0, 24'h010000, 8'hff, 4'b0001);
		t_control(24'h01011d, 0, 24'h000005, 8'h80, 4'b0101);
		t_control(24'h01011d, 8, 24'hfffffd, 8'h7f, 4'b1010);
		t_refuse();
		t_clear();
		print_verdict();
	end
endmodule
